// ===== rtl/timer_pair_pkg.sv
// Package with the register map, field layout, codes and carriers of the timer pair.
package timer_pair_pkg;

  // ----------------------------------------------------------------------------------------
  // Bus widths and register addresses
  // ----------------------------------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int UNITS  = 2;

  // Index 0 is unit 4, index 1 is unit 5.
  localparam logic [ADDR_W-1:0] ADDR_CTRL  [UNITS] = '{24'hffea40, 24'hffea41};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS [UNITS] = '{24'hffea42, 24'hffea43};
  localparam logic [ADDR_W-1:0] ADDR_MATCH_A [UNITS] = '{24'hffea44, 24'hffea45};
  localparam logic [ADDR_W-1:0] ADDR_MATCH_B [UNITS] = '{24'hffea46, 24'hffea47};
  localparam logic [ADDR_W-1:0] ADDR_COUNT [UNITS] = '{24'hffea48, 24'hffea49};
  localparam logic [ADDR_W-1:0] ADDR_EDGE  [UNITS] = '{24'hffea4a, 24'hffea4b};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 24'hffea4c;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK   = 24'hffea4d;
  localparam logic [ADDR_W-1:0] ADDR_STOP_HI      = 24'hfffdcc;
  localparam logic [ADDR_W-1:0] ADDR_STOP_LO      = 24'hfffdcd;

  // ----------------------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------------------
  localparam int CLR_SEL_LSB     = 3;
  localparam int CLK_SEL_LSB     = 0;
  localparam int FLAG_B_BIT      = 7;
  localparam int FLAG_A_BIT      = 6;
  localparam int FLAG_OVF_BIT    = 5;
  localparam int OUT_B_LSB       = 2;
  localparam int OUT_A_LSB       = 0;
  localparam int EDGE_FAST_BIT   = 0;
  localparam int EDGE_FALL_BIT   = 1;
  localparam int STOP_TIMER_BIT  = 13;
  localparam int EVT_PER_UNIT    = 3;
  localparam int EVT_W           = UNITS * EVT_PER_UNIT;
  localparam int PRESCALE_W      = 13;

  // ----------------------------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------------------------
  localparam logic [1:0] CLR_NONE   = 2'h0;
  localparam logic [1:0] CLR_ON_A   = 2'h1;
  localparam logic [1:0] CLR_ON_B   = 2'h2;
  localparam logic [1:0] OUT_KEEP   = 2'h0;
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  localparam logic [2:0] CLK_STOP    = 3'h0;
  localparam logic [2:0] CLK_FINE    = 3'h1;
  localparam logic [2:0] CLK_MID     = 3'h2;
  localparam logic [2:0] CLK_COARSE  = 3'h3;
  localparam logic [2:0] CLK_CASCADE = 3'h4;

  // Divider taps as powers of two: 2, 8, 32, 64, 1024, 8192.
  localparam logic [3:0] LOG2_DIV2    = 4'h1;
  localparam logic [3:0] LOG2_DIV8    = 4'h3;
  localparam logic [3:0] LOG2_DIV32   = 4'h5;
  localparam logic [3:0] LOG2_DIV64   = 4'h6;
  localparam logic [3:0] LOG2_DIV1024 = 4'ha;
  localparam logic [3:0] LOG2_DIV8192 = 4'hd;

  // ----------------------------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------------------------
  localparam logic [7:0]  COUNT_RESET = 8'h00;
  localparam logic [7:0]  MATCH_RESET = 8'hff;
  localparam logic [7:0]  COUNT_TOP   = 8'hff;
  localparam logic [15:0] STOP_RESET  = 16'hffff;

  // ----------------------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clear_sel;
    logic [2:0] clk_sel;
    logic [1:0] edge_sel;
    logic [1:0] out_b_sel;
    logic [1:0] out_a_sel;
  } unit_cfg_t;

  typedef struct packed {
    logic ovf;
    logic match_b;
    logic match_a;
  } unit_evt_t;

endpackage : timer_pair_pkg

// ===== rtl/cascaded_timer_pair.sv
// Pair of cascadable 8-bit compare-match timers with a serial base clock output.
//
// Notes on behaviour
// - With clear select 01 a unit's counter returns to zero on a match A.
// - With match-B output select 10 a match B drives the unit's wave output high.
// - With match-A output select 01 a match A drives the unit's wave output low.
// - The counter is compared with match-A value and equality on each new counter value while running sets match-A flag.
// - The counter is compared with match-B value and equality on each new counter value while running sets match-B flag.
// - Clock select 000 stops counting; 001 counts clock/8 or clock/2 on the chosen edge.
// - Clock select 010 counts clock/64 or clock/32 on the chosen edge.
// - Clock select 011 counts clock/8192 or clock/1024 on the chosen edge.
// - Clock select 100 in unit 4 counts each overflow of unit 5, edge select ignored.
// - Clock select 100 in unit 5 counts each match A of unit 4, edge select ignored.
// - Every counter and compare value is an 8-bit register that reads back and writes.
// - Bit 13 of the third module-stop register halts both timer units together.
// - A stop bit at 1 halts its module and at 0 lets it run.
// - The serial base clock is the AND of the two wave outputs.

// Index 0 of each per-unit array is unit 4, index 1 is unit 5.
module cascaded_timer_pair (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst,
  // Register port
  input  wire logic [timer_pair_pkg::ADDR_W-1:0]   addr,
  input  wire logic [timer_pair_pkg::DATA_W-1:0]   wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic      [timer_pair_pkg::DATA_W-1:0]   rdata,
  // Interrupt
  output logic                                     irq,
  // Waveform outputs
  output logic                                     unit4_wave_out,
  output logic                                     unit5_wave_out,
  output logic                                     sci_base_clock
);

  // ----------------------------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------------------------

  // Picks the divider tap for a clock select and the fast/slow half of the edge select.
  function automatic logic [3:0] div_log2(input logic [2:0] clk_sel, input logic fast);
    logic [3:0] res;

    res = timer_pair_pkg::LOG2_DIV8;
    if (clk_sel == timer_pair_pkg::CLK_FINE) begin
      res = fast ? timer_pair_pkg::LOG2_DIV2 : timer_pair_pkg::LOG2_DIV8;
    end else if (clk_sel == timer_pair_pkg::CLK_MID) begin
      res = fast ? timer_pair_pkg::LOG2_DIV32 : timer_pair_pkg::LOG2_DIV64;
    end else if (clk_sel == timer_pair_pkg::CLK_COARSE) begin
      res = fast ? timer_pair_pkg::LOG2_DIV1024 : timer_pair_pkg::LOG2_DIV8192;
    end
    return res;
  endfunction : div_log2

  // True in the cycle where divided clock bit (lg-1) of the prescaler is about to rise or
  // fall; the low lg bits then hold 0111..1 (rising) or 1111..1 (falling).
  function automatic logic tap_tick(input logic [timer_pair_pkg::PRESCALE_W-1:0] pre,
                                    input logic [3:0] lg, input logic falling);
    logic [timer_pair_pkg::PRESCALE_W-1:0] mask;
    logic [timer_pair_pkg::PRESCALE_W-1:0] target;

    mask   = (timer_pair_pkg::PRESCALE_W'(1) << lg) - timer_pair_pkg::PRESCALE_W'(1);
    target = falling ? mask : (mask >> 1);

    return (pre & mask) == target;
  endfunction : tap_tick

  // Applies match requests to a wave level; toggle beats high, high beats low.
  function automatic logic out_level(input logic cur, input logic [1:0] sel_a,
                                     input logic ev_a, input logic [1:0] sel_b,
                                     input logic ev_b);
    logic [1:0] req_a;
    logic [1:0] req_b;
    logic       res;

    req_a = ev_a ? sel_a : timer_pair_pkg::OUT_KEEP;
    req_b = ev_b ? sel_b : timer_pair_pkg::OUT_KEEP;
    res   = cur;

    if (req_a == timer_pair_pkg::OUT_TOGGLE || req_b == timer_pair_pkg::OUT_TOGGLE) begin
      res = ~cur;
    end else if (req_a == timer_pair_pkg::OUT_HIGH || req_b == timer_pair_pkg::OUT_HIGH) begin
      res = 1'b1;
    end else if (req_a == timer_pair_pkg::OUT_LOW || req_b == timer_pair_pkg::OUT_LOW) begin
      res = 1'b0;
    end
    return res;
  endfunction : out_level

  // ----------------------------------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------------------------------
  // Short local names for the package sizes.
  localparam int UNITS = timer_pair_pkg::UNITS;
  localparam int EVT_W = timer_pair_pkg::EVT_W;

  timer_pair_pkg::unit_cfg_t             cfg        [UNITS];
  timer_pair_pkg::unit_evt_t             evt        [UNITS];
  timer_pair_pkg::unit_evt_t             flags      [UNITS];
  logic [7:0]                            count      [UNITS];
  logic [7:0]                            match_a_val[UNITS];
  logic [7:0]                            match_b_val[UNITS];
  logic                                  wave       [UNITS];
  logic [timer_pair_pkg::DATA_W-1:0]     unit_rd    [UNITS];
  logic                                  unit_hit   [UNITS];

  logic [timer_pair_pkg::PRESCALE_W-1:0] prescale;
  logic [15:0]                           stop_ctrl;
  logic [EVT_W-1:0]                      evt_status;
  logic [EVT_W-1:0]                      evt_mask;
  logic                                  running;

  // Halting the pair freezes the prescaler, the counters and every match event.
  assign running = ~stop_ctrl[timer_pair_pkg::STOP_TIMER_BIT];

  // ----------------------------------------------------------------------------------------
  // Prescaler and module stop
  // ----------------------------------------------------------------------------------------

  // Free-running divider shared by both units so their taps stay phase-aligned.
  always_ff @(posedge clock) begin
    if (rst) begin
      prescale <= '0;
    end else if (running) begin
      prescale <= prescale + timer_pair_pkg::PRESCALE_W'(1);
    end
  end

  // Module-stop register, reached as two bytes; only bit 13 steers this block.
  logic wr_stop_hi;
  logic wr_stop_lo;
  assign wr_stop_hi = wr && (addr == timer_pair_pkg::ADDR_STOP_HI);
  assign wr_stop_lo = wr && (addr == timer_pair_pkg::ADDR_STOP_LO);

  always_ff @(posedge clock) begin
    if (rst) begin
      stop_ctrl <= timer_pair_pkg::STOP_RESET;
    end else if (wr_stop_hi) begin
      stop_ctrl[15:8] <= wdata;
    end else if (wr_stop_lo) begin
      // The low byte only reads back.
      stop_ctrl[7:0] <= wdata;
    end
  end

  // ----------------------------------------------------------------------------------------
  // Timer units
  // ----------------------------------------------------------------------------------------
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic       wr_ctrl;
    logic       wr_flags;
    logic       wr_match_a;
    logic       wr_match_b;
    logic       wr_count;
    logic       wr_edge;

    logic       cascade_in;
    logic       prescale_tick;
    logic       internal_src;
    logic       count_en;
    logic       eq_a;
    logic       eq_b;

    logic       clear_cnt;
    logic       updated;
    logic [2:0] flag_clear;
    logic [7:0] next_count;
    logic       next_wave;
    timer_pair_pkg::unit_evt_t next_flags;

    // Register decode for this unit.
    assign wr_ctrl    = wr && (addr == timer_pair_pkg::ADDR_CTRL[u]);
    assign wr_flags   = wr && (addr == timer_pair_pkg::ADDR_FLAGS[u]);
    assign wr_match_a = wr && (addr == timer_pair_pkg::ADDR_MATCH_A[u]);
    assign wr_match_b = wr && (addr == timer_pair_pkg::ADDR_MATCH_B[u]);
    assign wr_count   = wr && (addr == timer_pair_pkg::ADDR_COUNT[u]);
    assign wr_edge    = wr && (addr == timer_pair_pkg::ADDR_EDGE[u]);

    // Unit 4 counts overflows of unit 5; unit 5 counts match A of unit 4. The cascade
    // never loops because match events come only from registered state.
    assign cascade_in = (u == 0) ? evt[1].ovf : evt[0].match_a;

    // Count enable from the selected prescaler tap and edge.
    assign prescale_tick = tap_tick(prescale,
                                    div_log2(cfg[u].clk_sel,
                                             cfg[u].edge_sel[timer_pair_pkg::EDGE_FAST_BIT]),
                                    cfg[u].edge_sel[timer_pair_pkg::EDGE_FALL_BIT]);

    assign internal_src  = (cfg[u].clk_sel == timer_pair_pkg::CLK_FINE)
                        || (cfg[u].clk_sel == timer_pair_pkg::CLK_MID)
                        || (cfg[u].clk_sel == timer_pair_pkg::CLK_COARSE);

    assign count_en = running
                   && ((internal_src && prescale_tick)
                    || ((cfg[u].clk_sel == timer_pair_pkg::CLK_CASCADE) && cascade_in));

    // A match fires once per new counter value, so a held value makes one event only.
    assign eq_a = (count[u] == match_a_val[u]);
    assign eq_b = (count[u] == match_b_val[u]);

    assign evt[u].match_a = running && updated && eq_a;
    assign evt[u].match_b = running && updated && eq_b;
    assign evt[u].ovf     = count_en && (count[u] == timer_pair_pkg::COUNT_TOP);

    // Clear on match wins over a count in the same cycle; a software write wins over both.
    assign clear_cnt = ((cfg[u].clear_sel == timer_pair_pkg::CLR_ON_A) && evt[u].match_a)
                    || ((cfg[u].clear_sel == timer_pair_pkg::CLR_ON_B) && evt[u].match_b);

    assign next_count = wr_count  ? wdata :
                        clear_cnt ? timer_pair_pkg::COUNT_RESET :
                        count_en  ? count[u] + 8'h01 : count[u];

    // Flags clear by writing 0; an event in the same cycle keeps the flag set.
    assign flag_clear = wr_flags ? ~{wdata[timer_pair_pkg::FLAG_OVF_BIT],
                                     wdata[timer_pair_pkg::FLAG_B_BIT],
                                     wdata[timer_pair_pkg::FLAG_A_BIT]} : 3'h0;

    assign next_flags = (flags[u] & ~flag_clear) | evt[u];

    // Wave level changes only on matches and otherwise holds.
    assign next_wave = out_level(wave[u], cfg[u].out_a_sel, evt[u].match_a,
                                 cfg[u].out_b_sel, evt[u].match_b);

    // Counter and compare values.
    always_ff @(posedge clock) begin
      if (rst) begin
        count[u]       <= timer_pair_pkg::COUNT_RESET;
        match_a_val[u] <= timer_pair_pkg::MATCH_RESET;
        match_b_val[u] <= timer_pair_pkg::MATCH_RESET;
        updated        <= 1'b0;
      end else begin
        count[u] <= next_count;
        // Marks a new counter value for the compare.
        updated  <= wr_count || clear_cnt || count_en;

        if (wr_match_a) begin
          match_a_val[u] <= wdata;
        end
        if (wr_match_b) begin
          match_b_val[u] <= wdata;
        end
      end
    end

    // Configuration fields.
    always_ff @(posedge clock) begin
      if (rst) begin
        cfg[u] <= '0;
      end else begin
        if (wr_ctrl) begin
          cfg[u].clear_sel <= wdata[timer_pair_pkg::CLR_SEL_LSB +: 2];
          cfg[u].clk_sel   <= wdata[timer_pair_pkg::CLK_SEL_LSB +: 3];
        end

        if (wr_flags) begin
          cfg[u].out_b_sel <= wdata[timer_pair_pkg::OUT_B_LSB +: 2];
          cfg[u].out_a_sel <= wdata[timer_pair_pkg::OUT_A_LSB +: 2];
        end

        if (wr_edge) begin
          cfg[u].edge_sel <= wdata[1:0];
        end
      end
    end

    // Flags and wave level.
    always_ff @(posedge clock) begin
      if (rst) begin
        flags[u] <= '0;
        wave[u]  <= 1'b0;
      end else begin
        flags[u] <= next_flags;
        wave[u]  <= next_wave;
      end
    end

    // Read-back for this unit; reserved bits read as zero.
    logic [7:0] flags_rd;
    assign flags_rd = {flags[u].match_b, flags[u].match_a, flags[u].ovf, 1'b0,
                       cfg[u].out_b_sel, cfg[u].out_a_sel};

    assign unit_hit[u] = (addr == timer_pair_pkg::ADDR_CTRL[u])
                      || (addr == timer_pair_pkg::ADDR_FLAGS[u])
                      || (addr == timer_pair_pkg::ADDR_MATCH_A[u])
                      || (addr == timer_pair_pkg::ADDR_MATCH_B[u])
                      || (addr == timer_pair_pkg::ADDR_COUNT[u])
                      || (addr == timer_pair_pkg::ADDR_EDGE[u]);

    assign unit_rd[u] =
      (addr == timer_pair_pkg::ADDR_CTRL[u])    ? {3'h0, cfg[u].clear_sel, cfg[u].clk_sel} :
      (addr == timer_pair_pkg::ADDR_FLAGS[u])   ? flags_rd :
      (addr == timer_pair_pkg::ADDR_MATCH_A[u]) ? match_a_val[u] :
      (addr == timer_pair_pkg::ADDR_MATCH_B[u]) ? match_b_val[u] :
      (addr == timer_pair_pkg::ADDR_COUNT[u])   ? count[u] :
      (addr == timer_pair_pkg::ADDR_EDGE[u])    ? {6'h00, cfg[u].edge_sel} : 8'h00;
  end

  // ----------------------------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------------------------
  logic             wr_status;
  logic             wr_mask;

  logic [EVT_W-1:0] evt_now;
  logic [EVT_W-1:0] status_clear;
  logic [EVT_W-1:0] next_status;

  assign wr_status    = wr && (addr == timer_pair_pkg::ADDR_EVENT_STATUS);
  assign wr_mask      = wr && (addr == timer_pair_pkg::ADDR_EVENT_MASK);
  assign evt_now      = {evt[1], evt[0]};
  assign status_clear = wr_status ? wdata[EVT_W-1:0] : '0;

  // Writing 1 clears a bit, but an event arriving in the same cycle sets it again.
  assign next_status  = (evt_status & ~status_clear) | evt_now;

  always_ff @(posedge clock) begin
    if (rst) begin
      evt_status <= '0;
      evt_mask   <= '0;
    end else begin
      // Set beats clear, see next_status.
      evt_status <= next_status;
      if (wr_mask) begin
        evt_mask <= wdata[EVT_W-1:0];
      end
    end
  end

  // Level interrupt from registered status and mask only.
  assign irq = |(evt_status & evt_mask);

  // ----------------------------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------------------------
  // Unit windows first, then the pair-wide registers.
  logic [7:0] read_value;
  assign read_value =
    unit_hit[0] ? unit_rd[0] :
    unit_hit[1] ? unit_rd[1] :
    (addr == timer_pair_pkg::ADDR_EVENT_STATUS) ? {2'h0, evt_status} :
    (addr == timer_pair_pkg::ADDR_EVENT_MASK)   ? {2'h0, evt_mask} :
    (addr == timer_pair_pkg::ADDR_STOP_HI)      ? stop_ctrl[15:8] :
    (addr == timer_pair_pkg::ADDR_STOP_LO)      ? stop_ctrl[7:0] : 8'h00;

  // Read data stand only in the cycle after the strobe; otherwise they are zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      // Zero between reads.
      rdata <= rd ? read_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------------------
  // Wave outputs and serial base clock
  // ----------------------------------------------------------------------------------------
  // Waves leave straight from their flip-flops.
  assign unit4_wave_out = wave[0];
  assign unit5_wave_out = wave[1];

  // Both inputs are flip-flops, so the AND carries no glitch from the compare logic.
  assign sci_base_clock = wave[0] & wave[1];

endmodule : cascaded_timer_pair

// ===== test/cascaded_timer_pair_asserts.sv
// Port checker of the cascaded timer pair.
module cascaded_timer_pair_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic [23:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Outputs
  input wire logic        irq,
  input wire logic        unit4_wave_out,
  input wire logic        unit5_wave_out,
  input wire logic        sci_base_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shadow of the stop bit; reset leaves the pair halted.
  logic halted;
  always_ff @(posedge clock) begin
    if (rst) halted <= 1'b1;
    else if (wr && addr == 24'hfffdcc) halted <= wdata[5];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_base_and: assert property (sci_base_clock == (unit4_wave_out & unit5_wave_out))
    else $error("base clock differs from the AND of the waves");
  a_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data seen without a read");
  a_match_a_back: assert property ((wr && addr == 24'hffea45)
    ##1 (rd && addr == 24'hffea45) |=> rdata == $past(wdata, 2)) else $error("match A lost");
  a_match_b_back: assert property ((wr && addr == 24'hffea47)
    ##1 (rd && addr == 24'hffea47) |=> rdata == $past(wdata, 2)) else $error("match B lost");
  a_stop_back: assert property ((wr && addr == 24'hfffdcc)
    ##1 (rd && addr == 24'hfffdcc) |=> rdata[5] == $past(wdata[5], 2)) else $error("stop lost");
  a_flag_sticky: assert property ((rd && addr == 24'hffea42) ##1 (rdata[6] && !wr)
    ##1 (rd && addr == 24'hffea42) |=> rdata[6]) else $error("match flag fell alone");
  a_mask_irq: assert property (wr && addr == 24'hffea4d && wdata == 8'h00 |=> !irq)
    else $error("interrupt stays up with all masked");
  a_read_unmapped: assert property (rd && addr == 24'hffea50 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_halt_frozen: assert property (halted && $past(halted) && $past(halted, 2)
    |=> $stable(unit4_wave_out) && $stable(unit5_wave_out)) else $error("wave moved in halt");
  c_base: cover property ($rose(sci_base_clock));
  c_irq: cover property ($rose(irq));
  c_low5: cover property ($fell(unit5_wave_out));
endmodule : cascaded_timer_pair_asserts

bind cascaded_timer_pair cascaded_timer_pair_asserts u_asserts (.clock(clock), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .unit4_wave_out(unit4_wave_out), .unit5_wave_out(unit5_wave_out),
  .sci_base_clock(sci_base_clock));

// ===== test/sci_clock_sink.sv
// Model of the serial receiver that takes the base clock of the timer pair.
module sci_clock_sink (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Base clock from the timer pair
  input  wire logic base_clock,
  // Count of base clock rises
  output int        rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // The base clock comes from flops, so sampling it on the system clock sees every pulse.
  always_ff @(posedge clock) begin
    last <= rst ? 1'b0 : base_clock;
    rises <= rst ? 0 : rises + int'(base_clock && !last);
  end
endmodule : sci_clock_sink

// ===== test/cascaded_timer_pair_tb.sv
// Self-checking bench of the cascaded timer pair.
module cascaded_timer_pair_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [23:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic        clock, rst, wr, rd, irq, wave4, wave5, base;
  logic [23:0] addr;
  logic [7:0]  wdata, rdata, v, v0;
  int          rises, w4_rise, r0, k0, fails, checks;
  // Reset values, then write and read back; bits 7:5 of control read zero.
  row_t rows [15] = '{'{1'b0, 24'hffea44, 8'h00, 8'hff}, '{1'b0, 24'hffea47, 8'h00, 8'hff},
    '{1'b0, 24'hffea48, 8'h00, 8'h00}, '{1'b0, 24'hffea40, 8'h00, 8'h00},
    '{1'b0, 24'hffea42, 8'h00, 8'h00}, '{1'b0, 24'hffea4d, 8'h00, 8'h00},
    '{1'b0, 24'hfffdcc, 8'h00, 8'hff}, '{1'b1, 24'hffea45, 8'ha5, 8'ha5},
    '{1'b1, 24'hffea47, 8'h5a, 8'h5a}, '{1'b1, 24'hffea49, 8'h3c, 8'h3c},
    '{1'b1, 24'hffea41, 8'hff, 8'h1f}, '{1'b1, 24'hffea4b, 8'hff, 8'h03},
    '{1'b1, 24'hffea43, 8'hff, 8'h0f}, '{1'b1, 24'hffea50, 8'hff, 8'h00},
    '{1'b1, 24'hfffdcc, 8'hff, 8'hff}};
  // Clock source modes as {control, edge, log2 of divider}.
  logic [15:0] modes [13] = '{16'h0103, 16'h0111, 16'h0123, 16'h0131, 16'h0206, 16'h0215,
    16'h0226, 16'h0235, 16'h030d, 16'h031a, 16'h032d, 16'h033a, 16'h0015};
  logic [31:0] app [12] = '{32'hffea4009, 32'hffea4a01, 32'hffea4209, 32'hffea4401,
    32'hffea4600, 32'hffea4800, 32'hffea410c, 32'hffea4309, 32'hffea4503, 32'hffea4700,
    32'hffea4900, 32'hffea4d01};
  logic [31:0] ovf [5] = '{32'hffea4101, 32'hffea4b01, 32'hffea49fe, 32'hffea4004, 32'hffea4800};
  cascaded_timer_pair u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .unit4_wave_out(wave4), .unit5_wave_out(wave5),
    .sci_base_clock(base));
  sci_clock_sink u_sink (.clock(clock), .rst(rst), .base_clock(base), .rises(rises));
  // Clock at 10 MHz.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Wave rises of unit 4, the reference for the base clock.
  always @(posedge wave4) w4_rise++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One bus cycle; a read returns its data in v, taken mid-cycle where it has settled.
  task automatic op(input logic w, input logic [23:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    if (!w) begin
      rd <= 1'b0;
      @(negedge clock);
      v = rdata;
      @(posedge clock);
    end
  endtask : op
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic irq_is(input logic e);
    @(negedge clock);
    check({7'h00, irq}, {7'h00, e});
    @(posedge clock);
  endtask : irq_is
  task automatic close_out;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Watchdog well beyond the longest expected run.
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    close_out();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {rst, wr, rd, addr, wdata} <= {3'h4, 24'h000000, 8'h00};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) op(1'b1, rows[i].a, rows[i].d);
      op(1'b0, rows[i].a, 8'h00);
      check(v, rows[i].e);
    end
    op(1'b1, 24'hfffdcc, 8'hdf);
    // Over a window of twice the divider every counting mode gains exactly two counts; the stopped mode (control 00) gains none.
    foreach (modes[i]) begin
      op(1'b1, 24'hffea40, modes[i][15:8]);
      op(1'b1, 24'hffea4a, {4'h0, modes[i][7:4]});
      op(1'b0, 24'hffea48, 8'h00);
      v0 = v;
      idle((2 << modes[i][3:0]) - 2);
      op(1'b0, 24'hffea48, 8'h00);
      check(v - v0, (modes[i][15:8] == 8'h00) ? 8'h00 : 8'h02);
    end
    op(1'b1, 24'hfffdcc, 8'hff);
    foreach (app[i]) op(1'b1, app[i][31:8], app[i][7:0]);
    {r0, k0} = {rises, w4_rise};
    op(1'b1, 24'hfffdcc, 8'hdf);
    idle(200);
    op(1'b0, 24'hffea48, 8'h00);
    check({7'h00, v <= 8'h01}, 8'h01);
    op(1'b0, 24'hffea49, 8'h00);
    check({7'h00, v <= 8'h03}, 8'h01);
    op(1'b0, 24'hffea42, 8'h00);
    op(1'b0, 24'hffea42, 8'h00);
    check(v, 8'hc9);
    op(1'b0, 24'hffea43, 8'h00);
    check(v, 8'hc9);
    check({7'h00, w4_rise - k0 > 50}, 8'h01);
    check({7'h00, rises > r0 && rises - r0 < w4_rise - k0}, 8'h01);
    irq_is(1'b1);
    op(1'b1, 24'hffea4d, 8'h00);
    idle(1);
    irq_is(1'b0);
    op(1'b1, 24'hffea4d, 8'h01);
    op(1'b1, 24'hfffdcc, 8'hff);
    idle(3);
    op(1'b0, 24'hffea48, 8'h00);
    v0 = v;
    idle(20);
    op(1'b0, 24'hffea48, 8'h00);
    check(v, v0);
    op(1'b1, 24'hffea4c, 8'h3f);
    idle(1);
    irq_is(1'b0);
    op(1'b1, 24'hffea42, 8'h09);
    op(1'b0, 24'hffea42, 8'h00);
    check(v, 8'h09);
    // Unit 4 counts one wrap of unit 5 from fe within the short run.
    foreach (ovf[i]) op(1'b1, ovf[i][31:8], ovf[i][7:0]);
    op(1'b1, 24'hfffdcc, 8'hdf);
    idle(8);
    op(1'b1, 24'hfffdcc, 8'hff);
    idle(3);
    op(1'b0, 24'hffea48, 8'h00);
    check(v, 8'h01);
    rst <= 1'b1;
    idle(4);
    rst <= 1'b0;
    op(1'b0, 24'hfffdcc, 8'h00);
    check(v, 8'hff);
    op(1'b0, 24'hffea44, 8'h00);
    check(v, 8'hff);
    close_out();
  end
endmodule : cascaded_timer_pair_tb
